/* hdl/i2c_slave_port.sv */
// two-wire slave port with register file, clock stretching and scl generator
// Notes on behaviour
// - after start, compare received byte to own address
// - general call byte 00 matches when enabled
// - general call enable: 0 ignore, 1 accept
// - mismatch returns idle until next start
// - match with ack enable: flag, stretch clock
// - match without ack enable: idle, no answer
// - hold scl until all sources cleared
// - after each data byte: transfer-end flag, hold scl
// - transmit nack: stop sending, await stop/start
// - receive acks only while ack enable set
// - repeated start restarts address reception anywhere
// - stop sets flag; writing zero returns idle
// - sda changes hold value plus two after fall
// - master scl high lasts four times plus two
// - master scl low lasts four times plus two
// - pins open drain, pulling low only
// - data address: write transmit, read receive buffer
// - hold resets 01, periods 3F, status one 80
`timescale 1ns/1ps
`include "i2c_slave_port_cfg.svh"
module i2c_slave_port (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire i2c_slave_port_pkg::regReq_t regReq,
    output logic [7:0] regRdData,
    input wire i2c_slave_port_pkg::busPins_t pinIn,
    output i2c_slave_port_pkg::busPins_t pinOut,
    output i2c_slave_port_pkg::busPins_t pinOe
);
    import i2c_slave_port_pkg::*;

    // reset value of each plain register
    function automatic logic [7:0] rstVal(input logic [7:0] a);
        case (a)
            `OFF_ST1: rstVal = `RST_ST1;
            `OFF_BD: rstVal = `RST_BD;
            `OFF_SDHR: rstVal = `RST_SDHR;
            `OFF_SCLR, `OFF_SCHR: rstVal = `RST_PERIOD;
            default: rstVal = `RST_ZERO;
        endcase
    endfunction

    // registers that simply store what software writes
    function automatic logic isPlain(input logic [7:0] a);
        isPlain = a inside {`OFF_CR1, `OFF_CR2, `OFF_CR3, `OFF_CR4, `OFF_SAR,
            `OFF_ST1, `OFF_BD, `OFF_SDHR, `OFF_SCLR, `OFF_SCHR};
    endfunction

    logic [7:0] regs_q [0:`REG_SPAN-1]; // plain storage by index
    logic [7:0] rdData_q; // read answer, valid one cycle
    logic [2:0] sclSync_q; // [0] first stage, [2] previous level
    logic [2:0] sdaSync_q;
    slvState_t state_q;
    slvState_t state_d;
    logic [3:0] bitCnt_q; // rising edges seen in this byte
    logic [7:0] shift_q; // shared shift register
    logic [7:0] rxBuf_q; // receive buffer
    logic [7:0] txBuf_q; // transmit buffer
    logic txEmpty_q; // transmit buffer consumed
    logic rw_q; // direction bit of address byte
    logic rxAck_q; // master acked last sent byte
    logic endAfter_q; // leave transfer after this hold
    logic [3:0] st2Src_q; // sticky event bits
    logic drvLow_q; // pending sda level
    logic sdaLow_q; // sda pulled low now
    logic [8:0] holdCnt_q; // cycles left before sda update
    logic genLow_q; // master scl phase
    logic [9:0] genCnt_q;

    // register decode
    wire [7:0] relAddr = regReq.addr - `OFF_CR1;
    wire [3:0] regIdx = relAddr[3:0];
    wire plainWr = regReq.wr && isPlain(regReq.addr);
    wire st2Wr = regReq.wr && (regReq.addr == `OFF_ST2);
    wire drWr = regReq.wr && (regReq.addr == `OFF_DR);

    // configuration views
    wire [7:0] cr1 = regs_q[4'h0];
    wire [7:0] cr2 = regs_q[4'h1];
    wire [7:0] cr3 = regs_q[4'h2];
    wire [7:0] cr4 = regs_q[4'h3];
    wire [7:0] sar = regs_q[4'h4];
    wire [7:0] st1 = regs_q[4'h8];
    wire [7:0] sdhr = regs_q[4'hB];
    wire [7:0] sclr = regs_q[4'hD];
    wire [7:0] schr = regs_q[4'hE];
    wire unitOn = (cr1[`MODE_MSB:`MODE_LSB] == `MODE_TWO_WIRE) && cr2[`CR2_UNIT_EN];
    wire masterOn = unitOn && cr3[`CR3_MASTER];
    wire ackEn = cr4[`CR4_ACK_EN];
    wire [6:0] ownAddr = sar[7:1];
    wire gcEn = sar[0];

    // pin events, read only from the second stage on
    wire sdaLvl = sdaSync_q[1];
    wire sclRise = sclSync_q[1] && !sclSync_q[2];
    wire sclFall = !sclSync_q[1] && sclSync_q[2];
    // start and stop while scl high
    wire startEv = sclSync_q[1] && sclSync_q[2] && sdaSync_q[2] && !sdaLvl;
    wire stopEv = sclSync_q[1] && sclSync_q[2] && !sdaSync_q[2] && sdaLvl;

    // transfer decode
    wire srcAny = |st2Src_q;
    wire stopSeen = unitOn && stopEv && (state_q != S_IDLE);
    wire addrByteDone = (state_q == S_ADDR) && sclFall && (bitCnt_q == 4'h8);
    // upper seven bits against own address
    wire ownHit = shift_q[7:1] == ownAddr;
    // zero byte counts only when enabled
    wire gcHit = gcEn && (shift_q == `GCALL_BYTE);
    wire addrMatch = ownHit || gcHit;
    wire addrAccept = addrByteDone && addrMatch && ackEn;
    wire byteDoneRx = (state_q == S_RX) && sclFall && (bitCnt_q == 4'h8);
    wire byteDoneTx = (state_q == S_TX) && sclFall && (bitCnt_q == 4'h8);
    wire txBitFall = (state_q == S_TX) && sclFall && (bitCnt_q != 4'h8);
    wire ackEnd = sclFall && (state_q inside {S_ADDR_ACK, S_ACK_IN, S_ACK_OUT});
    wire holdDone = (state_q == S_HOLD) && !srcAny;
    wire slaveHold = state_q == S_HOLD; // kept through the load cycle so sda and scl change on one edge
    wire txLoad = holdDone && rw_q && !endAfter_q;
    wire sdaKill = !unitOn || startEv || stopSeen || txLoad;
    wire sdaReq = addrAccept || byteDoneRx || byteDoneTx || ackEnd || txBitFall;
    wire sdaReqLow = addrAccept || (byteDoneRx && ackEn) || (txBitFall && !shift_q[6]);
    wire [8:0] holdLoad = {1'b0, sdhr} + `HOLD_EXTRA;

    // read multiplexer, holes read zero
    wire [7:0] st2View = {rw_q, rxAck_q, 2'h0, st2Src_q};
    wire [7:0] rdMux =
        (regReq.addr == `OFF_ST2) ? st2View :
        (regReq.addr == `OFF_DR) ? rxBuf_q :
        (regReq.addr == `OFF_ST1) ? {txEmpty_q, st1[6:0]} :
        isPlain(regReq.addr) ? regs_q[regIdx] : 8'h00;

    // plain register writes
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `REG_SPAN; i++) begin
                regs_q[i] <= rstVal(8'(`OFF_CR1 + i));
            end
        end else if (plainWr) begin
            regs_q[regIdx] <= regReq.wdata;
        end
    end

    // read answer stands one cycle after the strobe only
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData_q <= 8'h00;
        end else begin
            // reading the data address returns receive buffer
            rdData_q <= regReq.rd ? rdMux : 8'h00;
        end
    end

    // two-stage synchronisers plus previous level
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclSync_q <= 3'h7;
            sdaSync_q <= 3'h7;
        end else begin
            // pins pass two flops before use
            sclSync_q <= {sclSync_q[1:0], pinIn.scl};
            sdaSync_q <= {sdaSync_q[1:0], pinIn.sda};
        end
    end

    // next state; start and stop win over byte progress
    always_comb begin
        state_d = state_q;
        if (!unitOn) begin
            state_d = S_IDLE;
        end else if (startEv) begin
            state_d = S_ADDR;
        end else if (stopSeen) begin
            state_d = S_STOPPED;
        end else begin
            case (state_q)
                S_ADDR: begin
                    // no ack enable also drops to idle
                    if (addrByteDone) state_d = addrAccept ? S_ADDR_ACK : S_IDLE;
                end
                S_ADDR_ACK, S_ACK_IN, S_ACK_OUT: begin
                    if (sclFall) state_d = S_HOLD;
                end
                S_HOLD: begin
                    // nack or refused byte ends the transfer
                    if (!srcAny) state_d = endAfter_q ? S_WAIT : (rw_q ? S_TX : S_RX);
                end
                S_TX: begin
                    if (byteDoneTx) state_d = S_ACK_IN;
                end
                S_RX: begin
                    if (byteDoneRx) state_d = S_ACK_OUT;
                end
                S_STOPPED: begin
                    // idle once the stop bit is written to zero
                    if (!st2Src_q[`ST2_STOP]) state_d = S_IDLE;
                end
                default: state_d = state_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) state_q <= S_IDLE;
        else state_q <= state_d;
    end

    // bit counter and shift register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
        end else if (startEv) begin
            bitCnt_q <= 4'h0;
        end else if (sclRise && (state_q inside {S_ADDR, S_RX, S_TX})) begin
            bitCnt_q <= bitCnt_q + 4'h1;
            // address and receive bits shift in msb first
            if (state_q != S_TX) shift_q <= {shift_q[6:0], sdaLvl};
        end else if (holdDone) begin
            bitCnt_q <= 4'h0;
            // transmit byte must already sit in the buffer
            if (rw_q) shift_q <= txBuf_q;
        end else if (txBitFall) begin
            shift_q <= {shift_q[6:0], 1'b0};
        end
    end

    // direction, ack status, end-of-transfer marker, receive buffer
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rw_q <= 1'b0;
            rxAck_q <= 1'b0;
            endAfter_q <= 1'b0;
            rxBuf_q <= 8'h00;
        end else if (addrAccept) begin
            rw_q <= shift_q[0];
            endAfter_q <= 1'b0;
        end else if ((state_q == S_ACK_IN) && sclRise) begin
            // high ack bit means the master refused more
            rxAck_q <= !sdaLvl;
            endAfter_q <= sdaLvl;
        end else if (byteDoneRx) begin
            rxBuf_q <= shift_q;
            // without ack enable the byte goes unanswered
            endAfter_q <= !ackEn;
        end
    end

    // transmit buffer; empty flag set by load wins over a write
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            txBuf_q <= 8'h00;
            txEmpty_q <= 1'b1;
        end else begin
            // writing the data address fills transmit buffer
            if (drWr) txBuf_q <= regReq.wdata;
            txEmpty_q <= txLoad || (txEmpty_q && !drWr);
        end
    end

    // sticky event bits; hardware set wins over software clear
    wire [3:0] st2Set = {ackEnd && (state_q == S_ADDR_ACK), stopSeen,
        ackEnd && (state_q != S_ADDR_ACK), addrAccept && gcHit};
    wire [3:0] st2Kept = st2Wr ? (st2Src_q & regReq.wdata[3:0]) : st2Src_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st2Src_q <= 4'h0;
        end else if (!unitOn) begin
            st2Src_q <= 4'h0;
        end else begin
            // slave-selected flag after the address ack
            // transfer-end flag after every data byte
            st2Src_q <= st2Kept | st2Set;
        end
    end

    // sda update delayed after the scl fall; start, stop and load act at once
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            drvLow_q <= 1'b0;
            sdaLow_q <= 1'b0;
            holdCnt_q <= 9'h000;
        end else if (sdaKill) begin
            // first data bit goes out on the same edge that scl is let go
            sdaLow_q <= txLoad && !txBuf_q[7];
            drvLow_q <= txLoad && !txBuf_q[7];
            holdCnt_q <= 9'h000;
        end else if (sdaReq) begin
            // delay of hold value plus two cycles
            drvLow_q <= sdaReqLow;
            holdCnt_q <= holdLoad;
        end else if (holdCnt_q != 9'h000) begin
            holdCnt_q <= holdCnt_q - 9'h001;
            if (holdCnt_q == 9'h001) sdaLow_q <= drvLow_q;
        end
    end

    // master scl generator: phase length is four times period plus two
    wire [9:0] lowLoad = {sclr, 2'b00} + `PER_ADD_M1;
    wire [9:0] highLoad = {schr, 2'b00} + `PER_ADD_M1;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            genLow_q <= 1'b0;
            genCnt_q <= 10'h000;
        end else if (!masterOn) begin
            genLow_q <= 1'b0;
            genCnt_q <= 10'h000;
        end else if (genCnt_q == 10'h000) begin
            genLow_q <= !genLow_q;
            genCnt_q <= genLow_q ? highLoad : lowLoad;
        end else begin
            genCnt_q <= genCnt_q - 10'h001;
        end
    end

    // open drain: output level fixed low, only enables move
    assign pinOut = '0;
    // scl held until sources cleared and byte loaded
    assign pinOe = {slaveHold || genLow_q, sdaLow_q};
    assign regRdData = rdData_q;

    // checking helpers: cycles since last sda request and phase length
    logic [8:0] sinceReq_q;
    logic [9:0] runLen_q;
    logic genSeen_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sinceReq_q <= 9'h1FF;
            runLen_q <= 10'h000;
            genSeen_q <= 1'b0;
        end else begin
            if (sdaReq) sinceReq_q <= 9'h001;
            else if (sinceReq_q != 9'h1FF) sinceReq_q <= sinceReq_q + 9'h001;
            runLen_q <= (genCnt_q == 10'h000) ? 10'h001 : runLen_q + 10'h001;
            genSeen_q <= masterOn && (genSeen_q || genCnt_q == 10'h000);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_addrDone;
        addrByteDone && !startEv;
    endsequence
    property p_addrMiss;
        s_addrDone and (!addrMatch) |=> state_q == S_IDLE;
    endproperty
    a_addrMiss: assert property (p_addrMiss) else $error("mismatch not idle");
    property p_ackOff;
        addrByteDone && addrMatch && !ackEn |=> state_q == S_IDLE && !pinOe.scl;
    endproperty
    a_ackOff: assert property (p_ackOff) else $error("answered with ack off");
    property p_gcall;
        addrByteDone && gcEn && shift_q == 8'h00 && ackEn |=> state_q == S_ADDR_ACK;
    endproperty
    a_gcall: assert property (p_gcall) else $error("general call refused");
    property p_sselHold;
        $rose(st2Src_q[`ST2_SSEL]) |-> pinOe.scl && state_q == S_HOLD;
    endproperty
    a_sselHold: assert property (p_sselHold) else $error("select without stretch");
    sequence s_stretch;
        state_q == S_HOLD && srcAny && unitOn && !startEv && !stopSeen;
    endsequence
    property p_holdLow;
        s_stretch |=> pinOe.scl;
    endproperty
    a_holdLow: assert property (p_holdLow) else $error("scl let go early");
    property p_release;
        holdDone && !masterOn |=> !pinOe.scl;
    endproperty
    a_release: assert property (p_release) else $error("scl not released");
    property p_tend;
        ackEnd && state_q != S_ADDR_ACK && unitOn && !stopSeen |=>
            st2Src_q[`ST2_TEND] && pinOe.scl;
    endproperty
    a_tend: assert property (p_tend) else $error("no transfer end hold");
    property p_nack;
        state_q == S_HOLD && endAfter_q && !srcAny && unitOn && !startEv |=>
            state_q == S_WAIT [*2];
    endproperty
    a_nack: assert property (p_nack) else $error("sent after nack");
    property p_rxAck;
        byteDoneRx && !sdaKill |=> drvLow_q == $past(ackEn) && endAfter_q == !$past(ackEn);
    endproperty
    a_rxAck: assert property (p_rxAck) else $error("wrong receive ack");
    property p_restart;
        startEv && unitOn |=> state_q == S_ADDR && bitCnt_q == 4'h0 && !sdaLow_q;
    endproperty
    a_restart: assert property (p_restart) else $error("start not honoured");
    property p_stop;
        stopSeen |=> st2Src_q[`ST2_STOP] && state_q == S_STOPPED;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not flagged");
    property p_holdTime;
        $changed(sdaLow_q) && !$past(sdaKill) |-> sinceReq_q == holdLoad + 9'h001;
    endproperty
    a_holdTime: assert property (p_holdTime) else $error("sda hold wrong");
    property p_highLen;
        genSeen_q && masterOn && !genLow_q && genCnt_q == 10'h000 |->
            runLen_q == {schr, 2'b00} + `PER_ADD;
    endproperty
    a_highLen: assert property (p_highLen) else $error("scl high length");
    property p_lowLen;
        genSeen_q && masterOn && genLow_q && genCnt_q == 10'h000 |->
            runLen_q == {sclr, 2'b00} + `PER_ADD;
    endproperty
    a_lowLen: assert property (p_lowLen) else $error("scl low length");
    property p_rdBuf;
        regReq.rd && regReq.addr == `OFF_DR |=> regRdData == $past(rxBuf_q);
    endproperty
    a_rdBuf: assert property (p_rdBuf) else $error("data read wrong");
endmodule

/* hdl/i2c_slave_port_cfg.svh */
// register offsets, field positions and reset values of the two-wire slave port
`ifndef I2C_SLAVE_PORT_CFG_SVH
`define I2C_SLAVE_PORT_CFG_SVH
`define OFF_CR1 8'hD9
`define OFF_CR2 8'hDA
`define OFF_CR3 8'hDB
`define OFF_CR4 8'hDC
`define OFF_SAR 8'hDD
`define OFF_ST1 8'hE1
`define OFF_ST2 8'hE2
`define OFF_BD 8'hE3
`define OFF_SDHR 8'hE4
`define OFF_DR 8'hE5
`define OFF_SCLR 8'hE6
`define OFF_SCHR 8'hE7
`define REG_SPAN 15
`define RST_ZERO 8'h00
`define RST_ST1 8'h80
`define RST_BD 8'hFF
`define RST_SDHR 8'h01
`define RST_PERIOD 8'h3F
`define MODE_MSB 7
`define MODE_LSB 6
`define MODE_TWO_WIRE 2'h2
`define CR2_UNIT_EN 1
`define CR3_MASTER 7
`define CR4_ACK_EN 4
`define CR4_IRQ_EN 0
`define ST1_TX_EMPTY 7
`define ST2_GCALL 0
`define ST2_TEND 1
`define ST2_STOP 2
`define ST2_SSEL 3
`define ST2_RXACK 6
`define ST2_DIR 7
`define GCALL_BYTE 8'h00
`define HOLD_EXTRA 9'h002
`define PER_ADD_M1 10'h001
`define PER_ADD 10'h002
`endif

/* hdl/i2c_slave_port_pkg.sv */
// shared types of the two-wire slave port
package i2c_slave_port_pkg;
    typedef struct packed {
        logic scl;
        logic sda;
    } busPins_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } regReq_t;
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_HOLD, S_TX, S_ACK_IN,
        S_RX, S_ACK_OUT, S_WAIT, S_STOPPED
    } slvState_t;
endpackage

/* sim/i2c_bus_master_model.sv */
// behavioural two-wire bus master on the far side of the slave port
`timescale 1ns/1ps
module i2c_bus_master_model (
    input wire logic sys_clk,
    input wire logic sclWire,
    input wire logic sdaWire,
    output logic sclLow,
    output logic sdaLow,
    output int stalls
);
    // master only pulls low; the bench forms the wires
    initial begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
        stalls = 0;
    end
    // wait in system clocks
    task automatic pause(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one bit at 25 clocks: data in low phase, sample at end of high
    task automatic bitCycle(input logic pull, output logic seen);
        int n;
        sdaLow <= pull;
        pause(6);
        sclLow <= 1'b0;
        n = 0;
        // bounded wait while the slave stretches, so a stuck hold is counted
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (sclWire !== 1'b1 && n < 3000);
        if (n >= 3000) stalls++;
        pause(12);
        #1;
        seen = sdaWire;
        sclLow <= 1'b1;
        pause(6);
    endtask
    // msb first, then the slave's answer bit
    task automatic writeByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitCycle(!b[i], s);
        bitCycle(1'b0, s);
        ack = !s;
    endtask
    // eight bits from the slave, then our own answer
    task automatic readByte(input logic ackIt, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bitCycle(1'b0, b[i]);
        bitCycle(ackIt, s);
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        sdaLow <= 1'b0;
        pause(6);
        sclLow <= 1'b0;
        pause(12);
        sdaLow <= 1'b1;
        pause(12);
        sclLow <= 1'b1;
        pause(6);
    endtask
    // stop: data rises while clock high
    task automatic stop();
        sdaLow <= 1'b1;
        pause(6);
        sclLow <= 1'b0;
        pause(12);
        sdaLow <= 1'b0;
        pause(12);
    endtask
endmodule

/* sim/i2c_slave_port_test.sv */
// self-checking bench for the two-wire slave port
`timescale 1ns/1ps
`include "i2c_slave_port_cfg.svh"
module i2c_slave_port_test;
    import i2c_slave_port_pkg::*;
    logic sys_clk = 1'b0; // 200 MHz
    logic reset_n = 1'b0;
    regReq_t req = '0;
    logic [7:0] rdData;
    busPins_t pinIn, pinOut, pinOe;
    logic sclLow, sdaLow, sclWire, sdaWire, ack;
    int stalls, miscompares = 0, nChecks = 0, cycles = 0;
    logic [7:0] d, t1, t2, abTab[4], sarTab[4], cr4Tab[4];
    logic [6:0] own;
    logic [7:0] rstAddr[13] = '{`OFF_CR1, `OFF_CR2, `OFF_CR3, `OFF_CR4, `OFF_SAR, `OFF_ST1,
        `OFF_ST2, `OFF_BD, `OFF_SDHR, `OFF_DR, `OFF_SCLR, `OFF_SCHR, 8'hE0};
    logic [7:0] rstVal[13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, `RST_ST1, 8'h00, `RST_BD,
        `RST_SDHR, 8'h00, `RST_PERIOD, `RST_PERIOD, 8'h00};
    assign sclWire = !pinOe.scl && !sclLow;
    assign sdaWire = !pinOe.sda && !sdaLow;
    assign pinIn = {sclWire, sdaWire};
    always #2.5 sys_clk = ~sys_clk;
    i2c_slave_port dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .regReq(req),
        .regRdData(rdData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
    i2c_bus_master_model model_u (.sys_clk(sys_clk), .sclWire(sclWire), .sdaWire(sdaWire),
        .sclLow(sclLow), .sdaLow(sdaLow), .stalls(stalls));
    // hang guard, generous against ~4k cycles of traffic
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            completeRun();
        end
    end
    task automatic completeRun();
        if (miscompares == 0 && nChecks > 0 && stalls == 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        nChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkBit(input string what, input logic exp, input logic got);
        chk8(what, {7'h00, exp}, {7'h00, got});
    endtask
    // one-cycle strobes, changed just after the edge
    task automatic wrReg(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic rdReg(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1;
        v = rdData;
    endtask
    task automatic chkSt2(input logic [7:0] mask, input logic [7:0] exp);
        logic [7:0] v;
        rdReg(`OFF_ST2, v);
        chk8("serial_status_two", exp, v & mask);
    endtask
    task automatic clearSt2();
        wrReg(`OFF_ST2, 8'h00);
    endtask
    // length of the next run of pinOe.scl at level lvl, in clocks
    task automatic phaseLen(input logic lvl, output logic [7:0] n);
        n = 8'h00;
        while (pinOe.scl !== lvl) begin
            @(posedge sys_clk);
            #1;
        end
        while (pinOe.scl === lvl) begin
            n++;
            @(posedge sys_clk);
            #1;
        end
    endtask
    // master phase length: four times the register plus two
    function automatic logic [7:0] expPhase(input logic [7:0] v);
        return 8'(4 * v + 2);
    endfunction
    // answer expected to an address byte
    function automatic logic expAck(input logic [7:0] ab, input logic [7:0] sar,
        input logic [7:0] cr4);
        return cr4[`CR4_ACK_EN] && (ab[7:1] == sar[7:1] || (ab == `GCALL_BYTE && sar[0]));
    endfunction
    initial begin
        void'($urandom(17560));
        own = 7'($urandom_range(2, 127));
        t1 = 8'($urandom);
        t2 = 8'($urandom);
        abTab = '{{own ^ 7'h01, 1'b0}, 8'h00, 8'h00, {own, 1'b0}};
        sarTab = '{{own, 1'b1}, {own, 1'b0}, {own, 1'b1}, {own, 1'b0}};
        cr4Tab = '{8'h11, 8'h11, 8'h11, 8'h01};
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            rdReg(rstAddr[i], d);
            chk8("reset value", rstVal[i], d);
        end
        wrReg(8'hE0, 8'hFF);
        rdReg(8'hE0, d);
        chk8("unmapped read", 8'h00, d);
        chk8("pin level", 8'h00, {6'h00, pinOut});
        wrReg(`OFF_CR1, 8'h80);
        wrReg(`OFF_CR2, 8'h02);
        // three clocks, well inside the bit time
        wrReg(`OFF_SDHR, 8'h01);
        // mismatch, general call off and on, ack enable off
        for (int i = 0; i < 4; i++) begin
            wrReg(`OFF_SAR, sarTab[i]);
            wrReg(`OFF_CR4, cr4Tab[i]);
            model_u.start();
            model_u.writeByte(abTab[i], ack);
            chkBit("address ack", expAck(abTab[i], sarTab[i], cr4Tab[i]), ack);
            if (expAck(abTab[i], sarTab[i], cr4Tab[i])) begin
                chkSt2(8'h01, 8'h01);
                clearSt2();
            end else begin
                model_u.writeByte(t1, ack);
                chkBit("ignored byte ack", 1'b0, ack);
                chkSt2(8'h0F, 8'h00);
            end
            model_u.stop();
            clearSt2();
        end
        // slave receive, then ack enable dropped
        wrReg(`OFF_SAR, {own, 1'b0});
        wrReg(`OFF_CR4, 8'h11);
        model_u.start();
        model_u.writeByte({own, 1'b0}, ack);
        chkBit("write address ack", 1'b1, ack);
        model_u.pause(20);
        chkBit("clock stretched", 1'b1, pinOe.scl);
        chkSt2(8'h0F, 8'h08);
        clearSt2();
        model_u.pause(4);
        chkBit("clock released", 1'b0, pinOe.scl);
        model_u.writeByte(t1, ack);
        chkBit("data ack", 1'b1, ack);
        chkSt2(8'h0F, 8'h02);
        rdReg(`OFF_DR, d);
        chk8("received byte", t1, d);
        wrReg(`OFF_CR4, 8'h01);
        clearSt2();
        model_u.writeByte(t2, ack);
        chkBit("data nack", 1'b0, ack);
        chkSt2(8'h0F, 8'h02);
        clearSt2();
        model_u.stop();
        chkSt2(8'h0F, 8'h04);
        clearSt2();
        chkSt2(8'hFF, 8'h00);
        // slave transmit, master nack, repeated start
        wrReg(`OFF_CR4, 8'h11);
        model_u.start();
        model_u.writeByte({own, 1'b1}, ack);
        chkSt2(8'h08, 8'h08);
        wrReg(`OFF_DR, t1);
        rdReg(`OFF_ST1, d);
        chk8("tx buffer empty", 8'h00, d & 8'h80);
        clearSt2();
        model_u.readByte(1'b1, d);
        chk8("sent byte", t1, d);
        rdReg(`OFF_ST1, d);
        chk8("tx buffer empty", 8'h80, d & 8'h80);
        chkSt2(8'h42, 8'h42);
        wrReg(`OFF_DR, t2);
        clearSt2();
        model_u.readByte(1'b0, d);
        chk8("last sent byte", t2, d);
        chkSt2(8'h42, 8'h02);
        clearSt2();
        model_u.pause(30);
        chkBit("data line released", 1'b0, pinOe.sda);
        model_u.start();
        model_u.writeByte({own, 1'b0}, ack);
        chkBit("restart address ack", 1'b1, ack);
        clearSt2();
        model_u.stop();
        chkSt2(8'h04, 8'h04);
        clearSt2();
        // master clock generator phases, random small periods
        t1 = 8'($urandom_range(1, 8));
        t2 = 8'($urandom_range(1, 8));
        wrReg(`OFF_SCLR, t1);
        wrReg(`OFF_SCHR, t2);
        wrReg(`OFF_CR3, 8'h80);
        phaseLen(1'b1, d);
        chk8("scl low length", expPhase(t1), d);
        phaseLen(1'b0, d);
        chk8("scl high length", expPhase(t2), d);
        completeRun();
    end
endmodule
